// ### core/sts_supervision_timer.sv
// Supervision timer: RC-stepped 24-bit down-counter with locked reload registers
`timescale 1ns/10ps
module sts_supervision_timer (
    input  wire logic           clk,
    input  wire logic           reset_n,
    input  wire logic           rc_osc,
    input  wire logic           always_on_option_bit,
    input  wire logic           timeout_response,
    input  wire logic           refresh_instr,
    input  wire sts_pkg::sts_req_s req,
    output logic [7:0]          rdata,
    output logic                rdata_valid,
    output logic                timeout_reset_req,
    output logic                timeout_irq,
    output logic                timer_on
);
    import sts_pkg::*;

    // ************************************************************
    // Declarations
    // ************************************************************
    logic             tick;
    sts_ulk_e         ulk;
    sts_ulk_e         next_ulk;
    logic [CNT_W-1:0] reload;
    logic [CNT_W-1:0] next_reload;
    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] next_count;
    logic             next_on;
    logic             flag;
    logic             next_flag;
    logic [7:0]       next_rdata;
    logic             next_rdata_valid;
    logic             next_reset_req;
    logic             next_irq;
    logic             fire;
    logic             ctl_wr;
    logic             ctl_rd;
    logic             refresh_ok;

    // ************************************************************
    // Oscillator edge
    // ************************************************************
    sts_tick_sync u_tick (
        .clk     (clk),
        .reset_n (reset_n),
        .osc_in  (rc_osc),
        .tick    (tick)
    );

    assign ctl_wr     = req.wr && (req.addr == ADDR_CTL);
    assign ctl_rd     = req.rd && (req.addr == ADDR_CTL);
    assign fire       = timer_on && tick && (count == TERMINAL);
    assign refresh_ok = refresh_instr && (!timer_on || count > REFRESH_FLOOR);

    // ************************************************************
    // Unlock sequencer
    // ************************************************************
    // Control writes steer only this state; no data bits are stored
    always_comb begin
        next_ulk = ulk;
        if (ctl_wr) begin
            case (ulk)
                ULK_LOCKED:    next_ulk = (req.wdata == UNLOCK_FIRST) ? ULK_GOT_FIRST : ULK_LOCKED;
                ULK_GOT_FIRST: next_ulk = (req.wdata == UNLOCK_SECOND) ? ULK_OPEN :
                                          (req.wdata == UNLOCK_FIRST) ? ULK_GOT_FIRST : ULK_LOCKED;
                ULK_OPEN:      next_ulk = (req.wdata == UNLOCK_FIRST) ? ULK_GOT_FIRST : ULK_LOCKED;
                default:       next_ulk = ULK_LOCKED;
            endcase
        end else if (req.wr && ulk == ULK_OPEN && req.addr == ADDR_LOW) begin
            next_ulk = ULK_LOCKED; // Low byte closes the window against stray writes
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            ulk <= ULK_LOCKED;
        end else begin
            ulk <= next_ulk;
        end
    end

    // ************************************************************
    // Reload bytes
    // ************************************************************
    always_comb begin
        next_reload = reload;
        if (req.wr && ulk == ULK_OPEN) begin
            case (req.addr)
                ADDR_UPPER: next_reload[23:16] = req.wdata;
                ADDR_HIGH:  next_reload[15:8]  = req.wdata;
                ADDR_LOW:   next_reload[7:0]   = req.wdata;
                default:    next_reload = reload;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            reload <= RELOAD_RESET;
        end else begin
            reload <= next_reload;
        end
    end

    // ************************************************************
    // Counter and enable
    // ************************************************************
    // No off path exists: only a reset with always_on_option_bit low stops a running timer
    always_comb begin
        next_on    = timer_on;
        next_count = count;
        if (refresh_ok) begin
            next_on    = 1'b1;
            next_count = reload;
        end else if (fire) begin
            next_count = reload; // Keeps counting after an interrupt response
        end else if (timer_on && tick) begin
            next_count = count - TERMINAL;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            timer_on <= always_on_option_bit;
            count    <= RELOAD_RESET;
        end else begin
            timer_on <= next_on;
            count    <= next_count;
        end
    end

    // ************************************************************
    // Timeout outputs and reset cause flag
    // ************************************************************
    // Set beats the clear so a timeout during a read is not lost
    always_comb begin
        next_reset_req = fire && (timeout_response == RESP_RESET);
        next_irq       = fire && (timeout_response == RESP_IRQ);
        next_flag      = flag;
        if (fire) begin
            next_flag = 1'b1;
        end else if (ctl_rd) begin
            next_flag = 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            timeout_reset_req <= 1'b0;
            timeout_irq       <= 1'b0;
            flag              <= 1'b0;
        end else begin
            timeout_reset_req <= next_reset_req;
            timeout_irq       <= next_irq;
            flag              <= next_flag;
        end
    end

    // ************************************************************
    // Read data
    // ************************************************************
    // Unmapped reads answer zero
    always_comb begin
        next_rdata       = 8'h00;
        next_rdata_valid = req.rd;
        if (req.rd) begin
            case (req.addr)
                ADDR_CTL: next_rdata[FLAG_BIT] = flag;
                ADDR_UPPER: next_rdata = count[23:16];
                ADDR_HIGH:  next_rdata = count[15:8];
                ADDR_LOW:   next_rdata = count[7:0];
                default:    next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rdata       <= 8'h00;
            rdata_valid <= 1'b0;
        end else begin
            rdata       <= next_rdata;
            rdata_valid <= next_rdata_valid;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    sequence s_second_byte;
        ulk == ULK_GOT_FIRST && ctl_wr && req.wdata == UNLOCK_SECOND;
    endsequence

    sequence s_opened;
        ulk == ULK_OPEN;
    endsequence

    property p_unlock;
        @(posedge clk) disable iff (!reset_n) s_second_byte |=> s_opened;
    endproperty
    a_unlock: assert property (p_unlock) else $error("Unlock sequence did not open reload bytes");

    property p_locked_hold;
        @(posedge clk) disable iff (!reset_n) (ulk != ULK_OPEN && req.wr) |=> $stable(reload);
    endproperty
    a_locked_hold: assert property (p_locked_hold) else $error("Locked reload value changed");

    property p_bad_order;
        @(posedge clk) disable iff (!reset_n)
            (ulk == ULK_GOT_FIRST && ctl_wr && req.wdata != UNLOCK_SECOND && req.wdata != UNLOCK_FIRST)
            |=> ulk == ULK_LOCKED;
    endproperty
    a_bad_order: assert property (p_bad_order) else $error("Broken unlock order left sequence open");

    property p_refresh_load;
        @(posedge clk) disable iff (!reset_n) refresh_ok |=> (count == $past(reload)) && timer_on;
    endproperty
    a_refresh_load: assert property (p_refresh_load) else $error("Refresh did not load reload value");

    property p_refresh_ignored;
        @(posedge clk) disable iff (!reset_n)
            (timer_on && refresh_instr && count <= REFRESH_FLOOR && count > TERMINAL && !tick)
            |=> $stable(count);
    endproperty
    a_refresh_ignored: assert property (p_refresh_ignored) else $error("Late refresh was accepted");

    property p_decrement;
        @(posedge clk) disable iff (!reset_n)
            (timer_on && tick && !refresh_ok && count > TERMINAL) |=> count == $past(count) - TERMINAL;
    endproperty
    a_decrement: assert property (p_decrement) else $error("Counter did not step on oscillator edge");

    sequence s_fire_reset;
        fire && timeout_response == RESP_RESET;
    endsequence

    property p_timeout_reset;
        @(posedge clk) disable iff (!reset_n) s_fire_reset |=> timeout_reset_req && !timeout_irq && flag;
    endproperty
    a_timeout_reset: assert property (p_timeout_reset) else $error("Reset response missing at terminal count");

    property p_flag_clear;
        @(posedge clk) disable iff (!reset_n) (ctl_rd && !fire) |=> !flag ##1 (!flag || $past(fire));
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("Reset cause read did not clear flag");

    property p_read_count;
        @(posedge clk) disable iff (!reset_n)
            (req.rd && req.addr == ADDR_LOW) |=> rdata_valid && rdata == $past(count[7:0]);
    endproperty
    a_read_count: assert property (p_read_count) else $error("Reload read did not return live count");

    property p_stays_on;
        @(posedge clk) disable iff (!reset_n) timer_on |=> timer_on;
    endproperty
    a_stays_on: assert property (p_stays_on) else $error("Running timer switched off");

    // ************************************************************
    // Response kinds, lock edges and byte writes
    // ************************************************************
    sequence s_fire_irq;
        fire && timeout_response == RESP_IRQ;
    endsequence

    property p_timeout_irq;
        @(posedge clk) disable iff (!reset_n) s_fire_irq |=> timeout_irq && !timeout_reset_req && flag;
    endproperty
    a_timeout_irq: assert property (p_timeout_irq) else $error("Interrupt response missing");

    // Ticks are at least two cycles apart, so a pulse never lasts two cycles
    property p_pulse_one;
        @(posedge clk) disable iff (!reset_n)
            (timeout_irq || timeout_reset_req) |=> !timeout_irq && !timeout_reset_req;
    endproperty
    a_pulse_one: assert property (p_pulse_one) else $error("Timeout pulse longer than one cycle");

    // A stopped timer holds its count; only a refresh, or a reset with always_on_option_bit high, may start it
    property p_off_still;
        @(posedge clk) disable iff (!reset_n) (!timer_on && !refresh_ok) |=> $stable(count) && !timer_on;
    endproperty
    a_off_still: assert property (p_off_still) else $error("Stopped timer moved without refresh");

    property p_ctl_no_store;
        @(posedge clk) disable iff (!reset_n) ctl_wr |=> $stable(reload);
    endproperty
    a_ctl_no_store: assert property (p_ctl_no_store) else $error("Control write changed reload value");

    property p_upper_write;
        @(posedge clk) disable iff (!reset_n)
            (ulk == ULK_OPEN && req.wr && req.addr == ADDR_UPPER) |=> reload[23:16] == $past(req.wdata);
    endproperty
    a_upper_write: assert property (p_upper_write) else $error("Upper reload byte not written");

    property p_high_write;
        @(posedge clk) disable iff (!reset_n)
            (ulk == ULK_OPEN && req.wr && req.addr == ADDR_HIGH) |=> reload[15:8] == $past(req.wdata);
    endproperty
    a_high_write: assert property (p_high_write) else $error("High reload byte not written");

    // Low byte is the last of a load, so it also closes the window
    property p_low_relock;
        @(posedge clk) disable iff (!reset_n)
            (ulk == ULK_OPEN && req.wr && req.addr == ADDR_LOW)
            |=> ulk == ULK_LOCKED && reload[7:0] == $past(req.wdata);
    endproperty
    a_low_relock: assert property (p_low_relock) else $error("Low byte write did not relock");

    property p_ctl_read;
        @(posedge clk) disable iff (!reset_n) ctl_rd |=> rdata_valid && rdata[FLAG_BIT] == $past(flag);
    endproperty
    a_ctl_read: assert property (p_ctl_read) else $error("Control address read missed reset cause");

endmodule : sts_supervision_timer

// ### core/sts_pkg.sv
// Constants, register map and carrier types for the supervision timer
// How it works
// - Terminal count resets or interrupts, per response
// - Counter steps on dedicated RC oscillator
// - One decrement per 10 kHz cycle
// - Only on/off; once on, always counts
// - Refresh instruction or always-on bit enables
// - Always-on bit starts counting out of reset
// - 24-bit reload from upper, high, low
// - Refresh loads reload value into counter
// - Refresh ignored at count 000002H or less
// - Reload bytes locked until 55H then AAH
// - Control writes only unlock; unlock writes store nothing
// - Control address reads give reset cause
// - Unlocked byte write updates its reload byte
// - Reload byte reads return live count
// - Reading reset cause clears timeout flag
package sts_pkg;

    // ************************************************************
    // Register map
    // ************************************************************
    localparam int           ADDR_W        = 12;
    localparam int           DATA_W        = 8;
    localparam int           CNT_W         = 24;
    localparam logic [11:0]  ADDR_CTL      = 12'hFF0; // Unlock writes, reset cause reads
    localparam logic [11:0]  ADDR_UPPER    = 12'hFF1;
    localparam logic [11:0]  ADDR_HIGH     = 12'hFF2;
    localparam logic [11:0]  ADDR_LOW      = 12'hFF3;

    // ************************************************************
    // Field values
    // ************************************************************
    localparam logic [7:0]   UNLOCK_FIRST  = 8'h55;
    localparam logic [7:0]   UNLOCK_SECOND = 8'hAA;
    localparam int           FLAG_BIT      = 5;       // Timeout flag in reset cause
    localparam logic [23:0]  REFRESH_FLOOR = 24'h000002;
    localparam logic [23:0]  RELOAD_MIN    = 24'h000004;
    localparam logic [23:0]  TERMINAL      = 24'h000001;
    localparam logic [23:0]  RELOAD_RESET  = 24'hFFFFFF;
    localparam int           RC_FREQ_KHZ   = 10;      // Typical oscillator rate
    localparam int           MS_DIVISOR    = 10;      // Time-out ms = reload / 10
    localparam logic         RESP_RESET    = 1'b0;
    localparam logic         RESP_IRQ      = 1'b1;

    // ************************************************************
    // Types
    // ************************************************************
    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [11:0]       addr;
        logic [7:0]        wdata;
    } sts_req_s;

    typedef enum logic [1:0] {
        ULK_LOCKED,
        ULK_GOT_FIRST,
        ULK_OPEN
    } sts_ulk_e;

endpackage : sts_pkg

// ### core/sts_tick_sync.sv
// Synchroniser and edge detector for the RC oscillator input
`timescale 1ns/10ps
module sts_tick_sync (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic osc_in,
    output logic      tick
);
    logic meta;
    logic sync;
    logic last;
    logic next_tick;

    // Rising edge of synchronised oscillator; meta feeds only sync
    always_comb begin
        next_tick = sync & ~last;
    end

    // Two-flop crossing, then one stage for the edge
    // Chain resets high: a pin already high at release must not pass for an edge
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            meta <= 1'b1;
            sync <= 1'b1;
            last <= 1'b1;
            tick <= 1'b0;
        end else begin
            meta <= osc_in;
            sync <= meta;
            last <= sync;
            tick <= next_tick;
        end
    end
endmodule : sts_tick_sync

// ### sim/sts_core_model.sv
// Core-side model: register accesses, refresh instruction and a fast RC oscillator
`timescale 1ns/10ps
module sts_core_model (
    input  wire logic              clk,
    input  wire logic [7:0]        rdata,
    input  wire logic              rdata_valid,
    output sts_pkg::sts_req_s      req,
    output logic                   refresh_instr,
    output logic                   rc_osc
);
    import sts_pkg::*;
    logic       osc_run;
    logic [2:0] osc_div;
    int         rises;
    initial begin
        req = '0;
        refresh_instr = 1'b0;
        rc_osc = 1'b0;
        osc_run = 1'b0;
        osc_div = 3'h0;
        rises = 0;
    end
    // Oscillator stands still unless a scenario runs it; 16 clk period keeps runs short
    always @(posedge clk) begin
        if (osc_run) begin
            osc_div <= osc_div + 3'h1;
            if (osc_div == 3'h7) begin
                rc_osc <= ~rc_osc;
                if (!rc_osc) rises <= rises + 1;
            end
        end
    end
    // One-cycle write strobe, released at the next edge
    task automatic write_reg(input logic [11:0] addr, input logic [7:0] data);
        @(posedge clk);
        req <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge clk);
        req <= '0;
    endtask : write_reg
    // Read data is registered, so it is sampled just after the taking edge
    task automatic read_reg(input logic [11:0] addr, output logic [7:0] data, output logic valid);
        @(posedge clk);
        req <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(posedge clk);
        req <= '0;
        #1;
        data = rdata;
        valid = rdata_valid;
    endtask : read_reg
    // Unlock then write upper, high, low; low byte last since it relocks
    task automatic load_reload(input logic [23:0] value);
        if (value < RELOAD_MIN) value = RELOAD_MIN;
        write_reg(ADDR_CTL, UNLOCK_FIRST);
        write_reg(ADDR_CTL, UNLOCK_SECOND);
        write_reg(ADDR_UPPER, value[23:16]);
        write_reg(ADDR_HIGH, value[15:8]);
        write_reg(ADDR_LOW, value[7:0]);
    endtask : load_reload
    // Periodic refresh keeps a running timer from expiring
    task automatic refresh();
        @(posedge clk);
        refresh_instr <= 1'b1;
        @(posedge clk);
        refresh_instr <= 1'b0;
    endtask : refresh
    // Service routine keeps reading the cause until the flag reads clear
    task automatic clear_flag(output int reads);
        logic [7:0] d;
        logic       v;
        reads = 0;
        do begin
            read_reg(ADDR_CTL, d, v);
            reads++;
        end while (d[FLAG_BIT] !== 1'b0 && reads < 8);
    endtask : clear_flag
endmodule : sts_core_model

// ### sim/testbench.sv
// Self-checking testbench for the supervision timer
`timescale 1ns/10ps
module testbench;
    import sts_pkg::*;
    logic       clk, reset_n, always_on_option_bit, timeout_response, refresh_instr, rc_osc;
    sts_req_s   req;
    logic [7:0] rdata;
    logic       rdata_valid, timeout_reset_req, timeout_irq, timer_on;
    int         n_mismatch, comparisons;

    sts_supervision_timer u_sts_supervision_timer (.clk(clk), .reset_n(reset_n), .rc_osc(rc_osc),
        .always_on_option_bit(always_on_option_bit), .timeout_response(timeout_response),
        .refresh_instr(refresh_instr), .req(req), .rdata(rdata), .rdata_valid(rdata_valid),
        .timeout_reset_req(timeout_reset_req), .timeout_irq(timeout_irq), .timer_on(timer_on));
    sts_core_model u_sts_core_model (.clk(clk), .rdata(rdata), .rdata_valid(rdata_valid), .req(req),
        .refresh_instr(refresh_instr), .rc_osc(rc_osc));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // ************************************************************
    // Shared helpers
    // ************************************************************
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic do_reset(input logic ao);
        @(posedge clk);
        always_on_option_bit <= ao;
        reset_n <= 1'b0;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        #1;
    endtask : do_reset
    // Reads one byte; the read also checks its valid pulse
    task automatic read_addr(input logic [11:0] a, output logic [7:0] d);
        logic v;
        u_sts_core_model.read_reg(a, d, v);
        check("rdata_valid", 24'h1, {23'h0, v});
    endtask : read_addr
    task automatic read_count(output logic [23:0] c);
        read_addr(ADDR_UPPER, c[23:16]);
        read_addr(ADDR_HIGH, c[15:8]);
        read_addr(ADDR_LOW, c[7:0]);
    endtask : read_count
    // Runs the oscillator until a timeout pulse, bounded; checks pulse kind, width and tick count
    task automatic wait_timeout(input logic irq, input int exp_rises);
        int i;
        #1; // Off the edge, clear of the oscillator's own update
        u_sts_core_model.rises = 0;
        u_sts_core_model.osc_run = 1'b1;
        for (i = 0; i < 3000; i++) begin
            @(posedge clk);
            #1;
            if (timeout_reset_req === 1'b1 || timeout_irq === 1'b1) break;
        end
        u_sts_core_model.osc_run = 1'b0;
        if (i == 3000) begin
            n_mismatch++;
            $display("mismatch timeout_wait expected pulse seen none");
            tally_and_finish();
        end
        check("ticks", 24'(exp_rises), 24'(u_sts_core_model.rises));
        check("reset_req", {23'h0, !irq}, {23'h0, timeout_reset_req});
        check("irq", {23'h0, irq}, {23'h0, timeout_irq});
        @(posedge clk);
        #1;
        check("pulse_end", 24'h0, {22'h0, timeout_reset_req, timeout_irq});
    endtask : wait_timeout
    // Runs the oscillator for n rising edges, bounded, then lets the last tick settle
    task automatic run_ticks(input int n);
        int i;
        #1;
        u_sts_core_model.rises = 0;
        u_sts_core_model.osc_run = 1'b1;
        for (i = 0; i < 500 && u_sts_core_model.rises < n; i++) @(posedge clk);
        #1;
        u_sts_core_model.osc_run = 1'b0;
        if (u_sts_core_model.rises != n) begin
            n_mismatch++;
            $display("mismatch run_ticks expected %0d seen %0d", n, u_sts_core_model.rises);
            tally_and_finish();
        end
        repeat (8) @(posedge clk);
    endtask : run_ticks

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset_values();
        logic [23:0] c;
        logic [7:0]  d;
        do_reset(1'b0);
        check("timer_on", 24'h0, {23'h0, timer_on});
        read_count(c);
        check("count", 24'hFFFFFF, c);
        read_addr(ADDR_CTL, d);
        check("cause", 24'h0, {16'h0, d});
        read_addr(12'h123, d);
        check("unmapped", 24'h0, {16'h0, d});
        $display("test reset_values done");
    endtask : t_reset_values
    task automatic t_locking();
        logic [23:0] c;
        logic [7:0]  d;
        u_sts_core_model.write_reg(ADDR_UPPER, 8'h12);
        u_sts_core_model.write_reg(ADDR_LOW, 8'h34);
        u_sts_core_model.write_reg(ADDR_CTL, UNLOCK_FIRST);
        u_sts_core_model.write_reg(ADDR_CTL, 8'h12);
        u_sts_core_model.write_reg(ADDR_CTL, UNLOCK_SECOND);
        u_sts_core_model.write_reg(ADDR_LOW, 8'h07);
        u_sts_core_model.refresh();
        #1;
        check("timer_on", 24'h1, {23'h0, timer_on});
        read_count(c);
        check("locked_count", 24'hFFFFFF, c);
        read_addr(ADDR_CTL, d);
        check("cause_after_unlock", 24'h0, {16'h0, d});
        $display("test locking done");
    endtask : t_locking
    task automatic t_reload_order();
        logic [23:0] c;
        u_sts_core_model.load_reload(24'h030201);
        u_sts_core_model.refresh();
        read_count(c);
        check("loaded_count", 24'h030201, c);
        $display("test reload_order done");
    endtask : t_reload_order
    task automatic t_timeout(input logic resp);
        int n;
        @(posedge clk);
        timeout_response <= resp;
        u_sts_core_model.load_reload(24'h000006);
        u_sts_core_model.refresh();
        wait_timeout(resp, 6);
        u_sts_core_model.clear_flag(n);
        check("flag_reads", 24'h2, n[23:0]);
        $display("test timeout done");
    endtask : t_timeout
    task automatic t_refresh_floor();
        logic [23:0] c;
        @(posedge clk);
        timeout_response <= RESP_RESET;
        u_sts_core_model.refresh();
        run_ticks(4);
        read_count(c);
        check("count_at_floor", 24'h000002, c);
        u_sts_core_model.refresh();
        read_count(c);
        check("refresh_ignored", 24'h000002, c);
        wait_timeout(1'b0, 2);
        $display("test refresh_floor done");
    endtask : t_refresh_floor
    task automatic t_always_on();
        logic [23:0] c;
        do_reset(1'b1);
        check("timer_on", 24'h1, {23'h0, timer_on});
        run_ticks(3);
        read_count(c);
        check("count_from_reset", 24'hFFFFFC, c);
        $display("test always_on done");
    endtask : t_always_on

    initial begin
        n_mismatch = 0;
        comparisons = 0;
        reset_n = 1'b0;
        always_on_option_bit = 1'b0;
        timeout_response = RESP_RESET;
        t_reset_values();
        t_locking();
        t_reload_order();
        t_timeout(RESP_RESET);
        t_timeout(RESP_IRQ);
        t_refresh_floor();
        t_always_on();
        tally_and_finish();
    end
endmodule : testbench
